// ### test/ext_count_source.sv
// External count source model driving the timer's count pin
`timescale 1ns/1ps
module ext_count_source (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [3:0] pulses,
  output logic pin,
  output logic busy
);
  logic [3:0] left_r;
  logic [1:0] ph_r;

  // Three-cycle half periods keep the rate under the sampling limit
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_r <= 4'h0;
      ph_r <= 2'h0;
      pin <= 1'b0;
    end
    else if (go && left_r == 4'h0)
      left_r <= pulses;
    else if (left_r != 4'h0)
    begin
      ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
      if (ph_r == 2'h2)
      begin
        pin <= ~pin;
        if (pin)
          left_r <= left_r - 4'h1;
      end
    end
  end

  // Idle low between bursts so selection changes see a stable pin
  assign busy = (left_r != 4'h0);
endmodule : ext_count_source

// ### test/tb_eight_bit_timer_count_core.sv
// Self-checking bench for the 8-bit timer core
`timescale 1ns/1ps
module tb_eight_bit_timer_count_core
  import timer_pkg::*;
();
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  logic [2:0] irq_ack = 3'h0;
  logic [2:0] irq_req;
  logic oca;
  logic ocb;
  logic pin;
  logic busy;
  logic go = 1'b0;
  logic [3:0] pulses = 4'h0;
  logic [31:0] seed = 32'h0000084d;
  logic [31:0] rd;
  logic err;
  logic [31:0] v;
  logic [7:0] c0;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int divs[6] = '{0, 1, 8, 64, 256, 1024};
  int w;

  always #5 mclk = ~mclk;

  eight_bit_timer_count_core dut_u (
    .mclk(mclk),
    .rst_n(rst_n),
    .apb_req(req),
    .apb_rsp(rsp),
    .ext_count_input(pin),
    .irq_ack(irq_ack),
    .irq_req(irq_req),
    .compare_out_a(oca),
    .compare_out_b(ocb)
  );

  ext_count_source src_u (
    .mclk(mclk),
    .rst_n(rst_n),
    .go(go),
    .pulses(pulses),
    .pin(pin),
    .busy(busy)
  );

  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] exp_ticks(int div, int gap);
    return (div == 0) ? 8'h00 : 8'(gap / div);
  endfunction : exp_ticks

  function automatic logic [2:0] exp_flags(logic [7:0] c);
    return {c > 8'h20, c > 8'h10, c < 8'hfe};
  endfunction : exp_flags

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic chk_bits(input string name, input logic [2:0] exp,
                          input logic [2:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bits

  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    req <= {1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do
      @(posedge mclk);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      test_done();
    end
  end

  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 32; a += 4)
    begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset value", 32'h0, rd);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk_bits("unmapped err", 3'h1, {2'h0, err});
    for (int i = 0; i < 9; i++)
    begin
      v = rnd();
      apb(1'b1, OFS_COUNT + 8'(4 * (i % 3)), v);
      apb(1'b0, OFS_COUNT + 8'(4 * (i % 3)), 32'h0);
      chk("reg readback", {24'h0, v[7:0]}, rd);
    end
    // Read spacing of 4 divisor periods makes the count step exact
    for (int cs = 0; cs < 6; cs++)
    begin
      w = (divs[cs] == 0) ? 5 : 4 * divs[cs] - 3;
      apb(1'b1, OFS_CTRL_B, 32'(cs));
      apb(1'b0, OFS_COUNT, 32'h0);
      c0 = rd[7:0];
      repeat (w) @(posedge mclk);
      apb(1'b0, OFS_COUNT, 32'h0);
      chk("tick step", exp_ticks(divs[cs], w + 3), 8'(rd[7:0] - c0));
    end
    apb(1'b1, OFS_CTRL_B, 32'h1);
    v = rnd();
    apb(1'b1, OFS_COUNT, v);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk("count write", {24'h0, v[7:0] + 8'h01}, rd);
    apb(1'b1, OFS_PRESC, 32'h1);
    apb(1'b0, OFS_PRESC, 32'h0);
    chk("prescaler ctrl", 32'h0, rd);
    apb(1'b1, OFS_CTRL_B, 32'h0);
    apb(1'b1, OFS_CMP_A, 32'h10);
    apb(1'b1, OFS_CMP_B, 32'h20);
    apb(1'b1, OFS_COUNT, 32'hfe);
    apb(1'b1, OFS_FLAG, 32'h7);
    apb(1'b1, OFS_MASK, 32'h7);
    apb(1'b1, OFS_CTRL_B, 32'h1);
    repeat (20) @(posedge mclk);
    apb(1'b1, OFS_CTRL_B, 32'h0);
    apb(1'b0, OFS_COUNT, 32'h0);
    c0 = rd[7:0];
    apb(1'b0, OFS_FLAG, 32'h0);
    chk_bits("flags", exp_flags(c0), rd[2:0]);
    chk_bits("irq all", exp_flags(c0), irq_req);
    apb(1'b1, OFS_MASK, 32'h1);
    repeat (3) @(posedge mclk);
    chk_bits("irq masked", exp_flags(c0) & 3'h1, irq_req);
    irq_ack <= 3'h1;
    @(posedge mclk);
    irq_ack <= 3'h0;
    apb(1'b0, OFS_FLAG, 32'h0);
    chk_bits("ack clear", exp_flags(c0) & 3'h6, rd[2:0]);
    apb(1'b1, OFS_FLAG, 32'h2);
    apb(1'b0, OFS_FLAG, 32'h0);
    chk_bits("w1c clear", exp_flags(c0) & 3'h4, rd[2:0]);
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, OFS_COUNT, 32'h0);
      apb(1'b1, OFS_CTRL_B, 32'(7 - k));
      pulses <= 4'(rnd() % 32'd15) + 4'h1;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      while (busy !== 1'b0)
        @(posedge mclk);
      // Covers the worst synchroniser delay of three and a half cycles
      repeat (4) @(posedge mclk);
      apb(1'b1, OFS_CTRL_B, 32'h0);
      apb(1'b0, OFS_COUNT, 32'h0);
      chk("ext edges", {28'h0, pulses}, rd);
    end
    // Normal mode: A sets at 0x10, B toggles at 0x20
    apb(1'b1, OFS_CTRL_A, {24'h0, COM_SET, COM_TOGGLE, 4'h0});
    apb(1'b1, OFS_COUNT, 32'h0);
    apb(1'b1, OFS_CTRL_B, 32'(CS_DIV1));
    repeat (40) @(posedge mclk);
    chk_bits("compare outs", 3'h3, {1'b0, ocb, oca});
    // Cleared prescaler puts the first divide-by-8 tick eight edges later
    apb(1'b1, OFS_CTRL_B, 32'(CS_DIV8));
    apb(1'b1, OFS_PRESC, 32'h1);
    apb(1'b1, OFS_COUNT, 32'h0);
    repeat (3) @(posedge mclk);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk("presc phase 0", 32'h0, rd);
    apb(1'b0, OFS_COUNT, 32'h0);
    chk("presc phase 1", 32'h1, rd);
    test_done();
  end
endmodule : tb_eight_bit_timer_count_core

// ### test/timer_core_monitor.sv
// Bus and reset checker bound to the timer core
`timescale 1ns/1ps
module timer_core_monitor
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire apb_req_s apb_req,
  input wire apb_rsp_s apb_rsp,
  input wire logic [2:0] irq_req,
  input wire logic compare_out_a,
  input wire logic compare_out_b
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire setup = apb_req.psel & ~apb_req.penable;
  wire mapped = apb_req.paddr[1:0] == 2'h0 && apb_req.paddr <= OFS_PRESC;
  wire rd_acc = apb_rsp.pready & ~apb_req.pwrite;

  a_ready_after_setup: assert property (setup |=> apb_rsp.pready)
    else $error("pready missing after setup");
  a_ready_in_access: assert property (
    apb_rsp.pready |-> apb_req.psel && apb_req.penable && $past(setup))
    else $error("pready outside an access cycle");
  a_ready_one_cycle: assert property (
    apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (
    setup && !mapped |=> apb_rsp.pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (
    setup && mapped |=> !apb_rsp.pslverr)
    else $error("mapped access refused");
  a_err_reads_zero: assert property (
    apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
    else $error("refused access returned data");
  a_upper_bits_zero: assert property (
    rd_acc |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> irq_req == 3'h0 && !compare_out_a && !compare_out_b)
    else $error("outputs active right after reset");
endmodule : timer_core_monitor

bind eight_bit_timer_count_core timer_core_monitor mon_u (
  .mclk(mclk),
  .rst_n(rst_n),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .irq_req(irq_req),
  .compare_out_a(compare_out_a),
  .compare_out_b(compare_out_b)
);

// ### verilog/eight_bit_timer_count_core.sv
// 8-bit timer/counter core with prescaler, external count input and APB
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - Count and both compare values are 8-bit software read/write registers.
// - Overflow, match A, match B latch in flag register, each masked.
// - Three-bit clock select picks prescaled clocks or external pin edge.
// - Clock select zero: no ticks, counter fully idle.
// - Clock select one ticks every system clock.
// - Four prescaler taps: divide by 8, 64, 256, 1024.
// - Prescaler runs freely regardless of clock select.
// - Software prescaler reset restarts the divider.
// - External pin via high-transparent latch, two flops, edge detect.
// - Select 7 counts rising edges, select 6 falling edges.
// - External edge updates counter 2.5 to 3.5 cycles later.
// - External edges bypass the prescaler, undivided.
// - Each tick clears, increments or decrements by mode and direction.
// - Count always accessible; software write beats clear or count.
// - Bottom is 0x00, maximum is 0xFF.
// - Top is 0xFF or compare A, by waveform mode.
// - Mode bits: two in control A, third in control B.
// - Both compares checked continuously, driving two compare outputs.
// - Match on A or B sets its flag, requesting if unmasked.
// - Overflow flag set at the mode's defined point, maskable.
// - Match flag sets one tick after equality; cleared when serviced.
// - Writing one to a flag bit clears it.
// - Normal mode counts up, wraps 0xFF to 0x00, flags overflow then.
module eight_bit_timer_count_core
  import timer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire apb_req_s apb_req,
  output apb_rsp_s apb_rsp,
  input wire logic ext_count_input,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req,
  output logic compare_out_a,
  output logic compare_out_b
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] control_reg_a_r;
  logic [7:0] control_reg_b_r;
  logic [7:0] count_value_r;
  logic [7:0] count_value_nxt;
  logic [7:0] compare_a_value_r;
  logic [7:0] compare_b_value_r;
  logic [2:0] timer_mask_reg_r;
  logic [2:0] timer_flag_reg_r;
  logic [2:0] timer_flag_reg_nxt;
  logic dir_down_r;
  logic dir_down_nxt;
  logic block_r;
  logic [9:0] presc_r;
  logic ext_latch_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_rise_r;
  logic ext_fall_r;
  logic oc_a_r;
  logic oc_b_r;
  logic [2:0] irq_req_r;
  apb_rsp_s apb_rsp_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire setup_phase = apb_req.psel & ~apb_req.penable;
  wire access_done = apb_req.psel & apb_req.penable & apb_rsp_r.pready;
  wire wr_en = access_done & apb_req.pwrite;
  wire [7:0] wbyte = apb_req.pwdata[7:0];
  wire hit_ctrl_a = apb_req.paddr == OFS_CTRL_A;
  wire hit_ctrl_b = apb_req.paddr == OFS_CTRL_B;
  wire hit_count = apb_req.paddr == OFS_COUNT;
  wire hit_cmp_a = apb_req.paddr == OFS_CMP_A;
  wire hit_cmp_b = apb_req.paddr == OFS_CMP_B;
  wire hit_mask = apb_req.paddr == OFS_MASK;
  wire hit_flag = apb_req.paddr == OFS_FLAG;
  wire hit_presc = apb_req.paddr == OFS_PRESC;
  wire hit_any = hit_ctrl_a | hit_ctrl_b | hit_count | hit_cmp_a |
                 hit_cmp_b | hit_mask | hit_flag | hit_presc;
  wire wr_ctrl_a = wr_en & hit_ctrl_a;
  wire wr_ctrl_b = wr_en & hit_ctrl_b;
  wire wr_count = wr_en & hit_count;
  wire wr_cmp_a = wr_en & hit_cmp_a;
  wire wr_cmp_b = wr_en & hit_cmp_b;
  wire wr_mask = wr_en & hit_mask;
  wire wr_flag = wr_en & hit_flag;
  wire presc_clear = wr_en & hit_presc & wbyte[PRESC_RST_BIT];

  wire [7:0] rd_byte =
    hit_ctrl_a ? control_reg_a_r :
    hit_ctrl_b ? control_reg_b_r :
    hit_count ? count_value_r :
    hit_cmp_a ? compare_a_value_r :
    hit_cmp_b ? compare_b_value_r :
    hit_mask ? {5'h00, timer_mask_reg_r} :
    hit_flag ? {5'h00, timer_flag_reg_r} :
    RST_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  wire [2:0] wave_mode = {control_reg_b_r[WGM2_BIT],
                          control_reg_a_r[WGM_HI:WGM_LO]};
  wire [2:0] clock_select_field = control_reg_b_r[CS_HI:CS_LO];
  wire [1:0] com_a = control_reg_a_r[COM_A_HI:COM_A_LO];
  wire [1:0] com_b = control_reg_a_r[COM_B_HI:COM_B_LO];
  wire mode_pc = wave_mode == WM_PC_FF || wave_mode == WM_PC_OCA;
  wire mode_fast = wave_mode == WM_FAST_FF || wave_mode == WM_FAST_OCA;
  wire mode_ctc = wave_mode == WM_CTC;
  wire top_is_cmp_a = mode_ctc || wave_mode == WM_PC_OCA ||
                      wave_mode == WM_FAST_OCA;
  wire [7:0] top_value = top_is_cmp_a ? compare_a_value_r : CNT_MAX;
  wire at_top = count_value_r == top_value;
  wire at_bottom = count_value_r == CNT_BOTTOM;
  wire at_max = count_value_r == CNT_MAX;

  ////////////////////////////////////////////////////////////////////////////
  // Clock select
  // Taps share one divider so a prescaler reset realigns all of them
  wire tap8 = (presc_r & TAP_8) == TAP_8;
  wire tap64 = (presc_r & TAP_64) == TAP_64;
  wire tap256 = (presc_r & TAP_256) == TAP_256;
  wire tap1024 = presc_r == TAP_1024;
  logic timer_tick;
  always_comb
  begin
    case (clock_select_field)
      CS_STOP: timer_tick = 1'b0;
      CS_DIV1: timer_tick = 1'b1;
      CS_DIV8: timer_tick = tap8;
      CS_DIV64: timer_tick = tap64;
      CS_DIV256: timer_tick = tap256;
      CS_DIV1024: timer_tick = tap1024;
      CS_EXT_FALL: timer_tick = ext_fall_r;
      CS_EXT_RISE: timer_tick = ext_rise_r;
      default: timer_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter unit
  wire match_a = timer_tick & ~block_r &
                 (count_value_r == compare_a_value_r);
  wire match_b = timer_tick & ~block_r &
                 (count_value_r == compare_b_value_r);
  logic overflow_evt;
  always_comb
  begin
    count_value_nxt = count_value_r;
    dir_down_nxt = dir_down_r;
    overflow_evt = 1'b0;
    if (timer_tick)
    begin
      if (mode_pc)
      begin
        if (!dir_down_r && at_top)
        begin
          dir_down_nxt = 1'b1;
          count_value_nxt = count_value_r - CNT_ONE;
        end
        else if (dir_down_r && at_bottom)
        begin
          dir_down_nxt = 1'b0;
          overflow_evt = 1'b1;
          count_value_nxt = count_value_r + CNT_ONE;
        end
        else if (dir_down_r)
          count_value_nxt = count_value_r - CNT_ONE;
        else
          count_value_nxt = count_value_r + CNT_ONE;
      end
      else if (mode_fast || mode_ctc)
      begin
        dir_down_nxt = 1'b0;
        overflow_evt = mode_fast ? at_top : at_max;
        count_value_nxt = at_top ? CNT_BOTTOM
                                 : count_value_r + CNT_ONE;
      end
      else
      begin
        // Normal mode; the reserved codes behave the same
        dir_down_nxt = 1'b0;
        overflow_evt = at_max;
        count_value_nxt = count_value_r + CNT_ONE;
      end
    end
    if (wr_count)
      count_value_nxt = wbyte;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: a hardware set wins over a simultaneous clear
  wire [2:0] flag_set = {match_b, match_a, overflow_evt};
  wire [2:0] flag_clr = (wr_flag ? wbyte[2:0] : 3'h0) | irq_ack;
  assign timer_flag_reg_nxt = (timer_flag_reg_r & ~flag_clr) |
                              flag_set;

  ////////////////////////////////////////////////////////////////////////////
  // Compare outputs
  function automatic logic oc_next(
    input logic cur,
    input logic [1:0] com,
    input logic match,
    input logic tick,
    input logic bottom,
    input logic fast,
    input logic pc,
    input logic down
  );
    logic val;
    val = cur;
    if (fast || pc)
    begin
      // Non-inverting for clear code, inverted for set code
      if (com == COM_CLEAR || com == COM_SET)
      begin
        if (match)
          val = (com == COM_SET) ^ (pc & down);
        else if (fast && tick && bottom)
          val = com == COM_CLEAR;
      end
    end
    else if (match)
    begin
      case (com)
        COM_TOGGLE: val = ~cur;
        COM_CLEAR: val = 1'b0;
        COM_SET: val = 1'b1;
        default: val = cur;
      endcase
    end
    return val;
  endfunction : oc_next

  // Fast PWM sets (clear code) or clears (set code) the output on a tick that wraps the count back to bottom without a compare match
  wire wrap_tick = timer_tick & at_top;
  wire oc_a_nxt = oc_next(oc_a_r, com_a, match_a, wrap_tick, 1'b1,
                          mode_fast, mode_pc, dir_down_r);
  wire oc_b_nxt = oc_next(oc_b_r, com_b, match_b, wrap_tick, 1'b1,
                          mode_fast, mode_pc, dir_down_r);

  ////////////////////////////////////////////////////////////////////////////
  // External pin synchroniser; latch modelled as a falling-edge stage
  always_ff @(negedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ext_latch_r <= 1'b0;
    else
      ext_latch_r <= ext_count_input;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_rise_r <= 1'b0;
      ext_fall_r <= 1'b0;
    end
    else
    begin
      ext_s1_r <= ext_latch_r;
      ext_s2_r <= ext_s1_r;
      // Registered edge gives the extra cycle of pin-to-count delay
      ext_rise_r <= ext_s2_r & ~ext_s1_r ? 1'b0 : ext_s1_r & ~ext_s2_r;
      ext_fall_r <= ext_s2_r & ~ext_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      presc_r <= PRESC_ZERO;
    else if (presc_clear)
      presc_r <= PRESC_ZERO;
    else
      presc_r <= presc_r + PRESC_ONE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_reg_a_r <= RST_BYTE;
      control_reg_b_r <= RST_BYTE;
      compare_a_value_r <= RST_BYTE;
      compare_b_value_r <= RST_BYTE;
      timer_mask_reg_r <= 3'h0;
    end
    else
    begin
      if (wr_ctrl_a)
        control_reg_a_r <= {wbyte[7:4], 2'h0, wbyte[1:0]};
      if (wr_ctrl_b)
        control_reg_b_r <= {4'h0, wbyte[3:0]};
      if (wr_cmp_a)
        compare_a_value_r <= wbyte;
      if (wr_cmp_b)
        compare_b_value_r <= wbyte;
      if (wr_mask)
        timer_mask_reg_r <= wbyte[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter state, flags and outputs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_value_r <= RST_BYTE;
      dir_down_r <= 1'b0;
      block_r <= 1'b0;
      timer_flag_reg_r <= 3'h0;
      irq_req_r <= 3'h0;
      oc_a_r <= 1'b0;
      oc_b_r <= 1'b0;
    end
    else
    begin
      count_value_r <= count_value_nxt;
      dir_down_r <= dir_down_nxt;
      // Count write hides any match on the next timer tick
      block_r <= wr_count | (block_r & ~timer_tick);
      timer_flag_reg_r <= timer_flag_reg_nxt;
      irq_req_r <= timer_flag_reg_nxt & timer_mask_reg_r;
      oc_a_r <= oc_a_nxt;
      oc_b_r <= oc_b_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB response: no wait states; pready and read data are registered in the setup cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      apb_rsp_r <= '0;
    else
    begin
      apb_rsp_r.pready <= setup_phase;
      apb_rsp_r.pslverr <= setup_phase & ~hit_any;
      if (setup_phase)
        apb_rsp_r.prdata <= {24'h000000, rd_byte};
    end
  end

  assign apb_rsp = apb_rsp_r;
  assign irq_req = irq_req_r;
  assign compare_out_a = oc_a_r;
  assign compare_out_b = oc_b_r;

endmodule : eight_bit_timer_count_core

// ### verilog/timer_pkg.sv
// Constants, register map and carrier types of the 8-bit timer core
package timer_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CTRL_B = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_CMP_A = 8'h0c;
  localparam logic [7:0] OFS_CMP_B = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_FLAG = 8'h18;
  localparam logic [7:0] OFS_PRESC = 8'h1c;

  // Field positions
  localparam int COM_A_HI = 7;
  localparam int COM_A_LO = 6;
  localparam int COM_B_HI = 5;
  localparam int COM_B_LO = 4;
  localparam int WGM_HI = 1;
  localparam int WGM_LO = 0;
  localparam int WGM2_BIT = 3;
  localparam int CS_HI = 2;
  localparam int CS_LO = 0;
  localparam int FLAG_OVF = 0;
  localparam int FLAG_MA = 1;
  localparam int FLAG_MB = 2;
  localparam int PRESC_RST_BIT = 0;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] CNT_ONE = 8'h01;

  // Prescaler: free running 10-bit divider, taps are all-ones patterns
  localparam logic [9:0] PRESC_ZERO = 10'h000;
  localparam logic [9:0] PRESC_ONE = 10'h001;
  localparam logic [9:0] TAP_8 = 10'h007;
  localparam logic [9:0] TAP_64 = 10'h03f;
  localparam logic [9:0] TAP_256 = 10'h0ff;
  localparam logic [9:0] TAP_1024 = 10'h3ff;

  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_DIV1 = 3'h1,
    CS_DIV8 = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } clock_sel_e;

  typedef enum logic [2:0] {
    WM_NORMAL = 3'h0,
    WM_PC_FF = 3'h1,
    WM_CTC = 3'h2,
    WM_FAST_FF = 3'h3,
    WM_RSVD4 = 3'h4,
    WM_PC_OCA = 3'h5,
    WM_RSVD6 = 3'h6,
    WM_FAST_OCA = 3'h7
  } wave_mode_e;

  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

endpackage : timer_pkg
